// file: src/board_csr_bank.sv
`timescale 1ns/1ps
`include "board_csr_defs.svh"

module board_csr_bank #(
  parameter logic [15:0] DEVICE_CODE = 16'h0abc, // arbitrary value
  parameter logic [15:0] VENDOR_CODE = 16'h0def, // arbitrary value
  parameter logic [5:0] REVISION = 6'h01
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register access, one aligned word per request
  input wire logic req,
  input wire logic req_write,
  input wire logic req_region0,
  input wire logic [7:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  output logic ack,
  output logic [31:0] rdata,
  // configuration identity
  output logic [15:0] device_id,
  output logic [15:0] vendor_id,
  output logic [31:0] bar0_size,
  output logic [31:0] bar1_size,
  // event sources
  input wire logic [7:0] event_in,
  output logic irq,
  // board controls
  output logic board_reset,
  output logic ctrl_big_endian,
  output logic pio_swap,
  output logic no_64bit,
  output logic word_swap,
  // scan port
  output logic scan_tck,
  output logic scan_tms,
  output logic scan_tdo,
  input wire logic scan_tdi,
  output logic scan_en,
  // straps
  input wire logic strap_low_volt,
  input wire logic strap_fast
);

  irq_bus ib();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  always_ff @(posedge clk)
  begin
    sync1_reg <= {scan_tdi, strap_low_volt, strap_fast};
    sync2_reg <= sync1_reg;
  end

  // ----------------------------------------
  // reset and access decode
  // ----------------------------------------
  logic soft_reset_reg;
  logic rst_any;
  logic full_word;
  logic hit_int;
  logic hit_brd;
  logic wr_int;
  logic wr_brd;
  logic take;
  board_csr_pkg::bus_state_type state_reg;
  board_csr_pkg::bus_state_type state_next;

  assign rst_any = !resetn || soft_reset_reg;
  assign full_word = req_be == 4'hf;
  assign take = req && state_reg == board_csr_pkg::ST_IDLE;
  assign hit_int = req_region0 && full_word && req_addr == `OFS_INT;
  assign hit_brd = req_region0 && full_word && req_addr == `OFS_BRD;
  assign wr_int = take && req_write && hit_int;
  assign wr_brd = take && req_write && hit_brd;

  // one wait state, then ack
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      board_csr_pkg::ST_IDLE:
      begin
        if (req)
          state_next = board_csr_pkg::ST_ACK;
      end
      board_csr_pkg::ST_ACK:
        state_next = board_csr_pkg::ST_IDLE;
      default:
        state_next = board_csr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_reg <= board_csr_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  assign ack = state_reg == board_csr_pkg::ST_ACK;

  // board reset is a one-cycle pulse; it clears the bank itself too
  always_ff @(posedge clk)
  begin
    if (!resetn)
      soft_reset_reg <= 1'b0;
    else
      soft_reset_reg <= wr_brd && req_wdata[`BRD_RESET];
  end
  assign board_reset = soft_reset_reg;

  // ----------------------------------------
  // interrupt register
  // ----------------------------------------
  logic [7:0] enable_reg;
  always_ff @(posedge clk)
  begin
    if (rst_any)
      enable_reg <= 8'h00;
    else if (wr_int)
      enable_reg <= req_wdata[`INT_EN_LSB +: `INT_SRC_N];
  end

  assign ib.event_in = event_in;
  assign ib.clear = wr_int ? req_wdata[`INT_PEND_LSB +: `INT_SRC_N] : 8'h00;
  assign ib.enable = enable_reg;

  irq_pending u_pend (
    .clk(clk),
    .rst_any(rst_any),
    .ib(ib)
  );
  assign irq = ib.irq;

  // ----------------------------------------
  // board control register
  // ----------------------------------------
  logic little_reg;
  logic big_reg;
  logic pio_swap_reg;
  logic [2:0] scan_out_reg;
  logic scan_en_reg;
  logic no64_reg;
  logic wswap_reg;

  // writing 0 to the little-endian bit changes nothing
  always_ff @(posedge clk)
  begin
    if (rst_any)
      little_reg <= 1'b1;
    else if (wr_brd && req_wdata[`BRD_LITTLE])
      little_reg <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      big_reg <= 1'b0;
      pio_swap_reg <= 1'b0;
      scan_out_reg <= 3'h0;
      scan_en_reg <= 1'b0;
      no64_reg <= 1'b0;
      wswap_reg <= 1'b0;
    end
    else if (wr_brd)
    begin
      big_reg <= req_wdata[`BRD_BIG];
      pio_swap_reg <= req_wdata[`BRD_PIO_SWAP];
      scan_out_reg <= req_wdata[`BRD_TDO:`BRD_TCK];
      scan_en_reg <= req_wdata[`BRD_SCAN_EN];
      no64_reg <= req_wdata[`BRD_NO64];
      wswap_reg <= req_wdata[`BRD_WSWAP];
    end
  end

  assign ctrl_big_endian = big_reg;
  assign pio_swap = pio_swap_reg;
  assign scan_tck = scan_out_reg[0];
  assign scan_tms = scan_out_reg[1];
  assign scan_tdo = scan_out_reg[2];
  assign scan_en = scan_en_reg;
  assign no_64bit = no64_reg;
  assign word_swap = wswap_reg;

  // ----------------------------------------
  // configuration identity
  // ----------------------------------------
  assign device_id = DEVICE_CODE;
  assign vendor_id = VENDOR_CODE;
  assign bar0_size = 32'(`WIN_BYTES);
  assign bar1_size = `FIFO_WIN_BYTES;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] int_word;
  logic [31:0] brd_word;
  logic [31:0] rd_sel;
  logic [31:0] rdata_reg;
  logic tdi_seen_reg;

  // scan input reads 1 until sampled after reset
  always_ff @(posedge clk)
  begin
    if (rst_any)
      tdi_seen_reg <= 1'b1;
    else
      tdi_seen_reg <= sync2_reg[2];
  end

  assign int_word = {8'h00, enable_reg, 8'h00, ib.pending};
  assign brd_word = {5'h00, wswap_reg, no64_reg, big_reg, 8'h00,
                     sync2_reg[0], sync2_reg[1], REVISION,
                     scan_en_reg, tdi_seen_reg, scan_out_reg,
                     pio_swap_reg, 1'b0, little_reg};
  // dma sets and reserved space read zero here
  assign rd_sel = hit_int ? int_word : (hit_brd ? brd_word : 32'h0000_0000);

  always_ff @(posedge clk)
  begin
    if (rst_any)
      rdata_reg <= 32'h0000_0000;
    else if (take && !req_write)
      rdata_reg <= rd_sel;
  end
  assign rdata = rdata_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // one wait state: the answer is a single-cycle pulse
  sequence seq_ack_pulse;
    ack ##1 !ack;
  endsequence

  // the board reset pulse empties enables and pending bits one edge later
  sequence seq_bank_cleared;
    board_reset ##1 (enable_reg == 8'h00 && ib.pending == 8'h00);
  endsequence

  AST_IRQ_TRACK: assert property (@(posedge clk) disable iff (rst_any)
    irq == |(ib.pending & enable_reg))
    else $error("irq does not follow pending and enable");
  AST_LITTLE_STICKS: assert property (@(posedge clk) disable iff (rst_any)
    little_reg |=> little_reg)
    else $error("little-endian bit cleared");
  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!resetn)
    (wr_brd && req_wdata[`BRD_RESET]) |=> seq_bank_cleared)
    else $error("board reset not applied");
  // a zero in the reset bit must not pulse it; rst_any would hide the pulse, so plain reset only
  AST_RESET_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    (wr_brd && !req_wdata[`BRD_RESET]) |=> !board_reset)
    else $error("board reset pulsed on a zero write");
  AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (rst_any)
    wr_int |=> enable_reg == $past(req_wdata[`INT_EN_LSB +: `INT_SRC_N]))
    else $error("enable write lost");
  AST_NO64: assert property (@(posedge clk) disable iff (rst_any)
    wr_brd |=> no_64bit == $past(req_wdata[`BRD_NO64]))
    else $error("64-bit disable wrong");
  AST_WSWAP: assert property (@(posedge clk) disable iff (rst_any)
    wr_brd |=> word_swap == $past(req_wdata[`BRD_WSWAP]))
    else $error("word swap wrong");
  AST_RSVD_READ: assert property (@(posedge clk) disable iff (rst_any)
    (take && !req_write && req_addr >= `OFS_RSVD) |=> rdata == 32'h0000_0000)
    else $error("reserved address read nonzero");
  AST_ACK: assert property (@(posedge clk) disable iff (!resetn)
    take |=> seq_ack_pulse)
    else $error("ack timing wrong");
  AST_BIG: assert property (@(posedge clk) disable iff (rst_any)
    wr_brd |=> ctrl_big_endian == $past(req_wdata[`BRD_BIG]))
    else $error("big-endian control wrong");
  AST_PIO_SWAP: assert property (@(posedge clk) disable iff (rst_any)
    wr_brd |=> pio_swap == $past(req_wdata[`BRD_PIO_SWAP]))
    else $error("programmed transfer swap wrong");
  AST_SCAN_OUT: assert property (@(posedge clk) disable iff (rst_any)
    wr_brd |=> {scan_tdo, scan_tms, scan_tck} == $past(req_wdata[`BRD_TDO:`BRD_TCK]))
    else $error("scan port lines wrong");
  // refused accesses must leave the enables and the board control fields other than the little-endian bit alone
  AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (rst_any)
    (take && req_write && !hit_int && !hit_brd) |=>
      $stable({enable_reg, big_reg, pio_swap_reg, scan_out_reg,
               scan_en_reg, no64_reg, wswap_reg}))
    else $error("refused write changed a register");

endmodule

// file: src/board_csr_defs.svh
`ifndef BOARD_CSR_DEFS_SVH
`define BOARD_CSR_DEFS_SVH

// ----------------------------------------
// register window
// ----------------------------------------
`define WIN_BYTES 256
`define OFS_INT 8'h00
`define OFS_BRD 8'h04
`define OFS_DMA0 8'h20
`define OFS_DMA1 8'h50
`define OFS_RSVD 8'h80
`define FIFO_WIN_BYTES 32'h0010_0000

// ----------------------------------------
// interrupt register fields
// ----------------------------------------
`define INT_PEND_LSB 0
`define INT_EN_LSB 16
`define INT_SRC_N 8

// ----------------------------------------
// board control fields
// ----------------------------------------
`define BRD_LITTLE 0
`define BRD_RESET 1
`define BRD_PIO_SWAP 2
`define BRD_TCK 3
`define BRD_TMS 4
`define BRD_TDO 5
`define BRD_TDI 6
`define BRD_SCAN_EN 7
`define BRD_REV_LSB 8
`define BRD_LOWV 14
`define BRD_FAST 15
`define BRD_BIG 24
`define BRD_NO64 25
`define BRD_WSWAP 26

`endif

// file: src/board_csr_pkg.sv
package board_csr_pkg;
  // bus access phases
  typedef enum logic [1:0] {ST_IDLE, ST_ACK} bus_state_type;
endpackage

// file: src/irq_bus.sv
`timescale 1ns/1ps
// pending/enable traffic between the bank and the interrupt logic
interface irq_bus;
  logic [7:0] event_in;
  logic [7:0] clear;
  logic [7:0] enable;
  logic [7:0] pending;
  logic irq;
  modport bank (output event_in, output clear, output enable, input pending, input irq);
  modport core (input event_in, input clear, input enable, output pending, output irq);
endinterface

// file: src/irq_pending.sv
`timescale 1ns/1ps
`include "board_csr_defs.svh"

module irq_pending
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_any,
  // bank side
  irq_bus.core ib
);

  logic [7:0] pend_reg;
  logic [7:0] pend_next;

  // set wins over a simultaneous clear
  assign pend_next = (pend_reg & ~ib.clear) | ib.event_in;

  // ----------------------------------------
  // pending latches
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst_any)
      pend_reg <= 8'h00;
    else
      pend_reg <= pend_next;
  end

  assign ib.pending = pend_reg;
  assign ib.irq = |(pend_reg & ib.enable);

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst_any)
    (ib.event_in[0] && ib.clear[0]) |=> pend_reg[0])
    else $error("event lost under clear");
  AST_CLEAR: assert property (@(posedge clk) disable iff (rst_any)
    (ib.clear[3] && !ib.event_in[3]) |=> !pend_reg[3])
    else $error("pending bit not cleared");

endmodule

// file: testbench/pci_host_model.sv
`timescale 1ns/1ps
// behavioural host master, one aligned word per access
module pci_host_model
(
  // clock
  input wire logic clk,
  // request
  output logic req,
  output logic req_write,
  output logic req_region0,
  output logic [7:0] req_addr,
  output logic [3:0] req_be,
  output logic [31:0] req_wdata,
  // answer
  input wire logic ack,
  input wire logic [31:0] rdata
);
  initial
  begin
    req = 1'b0;
    req_write = 1'b0;
    req_region0 = 1'b1;
    req_addr = 8'h00;
    req_be = 4'hf;
    req_wdata = 32'h0000_0000;
  end

  // held from a falling edge until the falling edge after ack is sampled; released data is inverted
  // no local limit: a lost ack is caught by the bench's hang guard and counted
  task automatic xfer(input logic w, input logic r0, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d, output logic [31:0] rd);
    begin
      @(negedge clk);
      req = 1'b1;
      req_write = w;
      req_region0 = r0;
      req_addr = a;
      req_be = be;
      req_wdata = d;
      do
      begin
        @(negedge clk);
      end
      while (ack !== 1'b1);
      @(posedge clk);
      rd = rdata;
      @(negedge clk);
      req = 1'b0;
      req_wdata = ~d;
    end
  endtask
endmodule

// file: testbench/board_csr_bank_tb_top.sv
`timescale 1ns/1ps
module board_csr_bank_tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] rx; logic [7:0] ox;} row_type;
  logic clk, resetn, req, req_write, req_region0, ack, irq, board_reset;
  logic [7:0] req_addr, event_in, outs;
  logic [3:0] req_be;
  logic [31:0] req_wdata, rdata, bar0_size, bar1_size, rv;
  logic [15:0] device_id, vendor_id;
  logic cbe, psw, n64, wsw, tck, tms, tdo, sen, scan_tdi, strap_low_volt, strap_fast;
  int n_fail = 0, tests_run = 0, cycles = 0, pulses = 0;
  row_type rows[5] = '{
    '{8'h04, 32'hffff_fffd, 32'h0700_6afd, 8'hff},
    '{8'h04, 32'h0000_0000, 32'h0000_6a41, 8'h00},
    '{8'h00, 32'hffff_ff00, 32'h00ff_0000, 8'h00},
    '{8'h80, 32'hffff_ffff, 32'h0000_0000, 8'h00},
    '{8'h50, 32'hffff_ffff, 32'h0000_0000, 8'h00}};
  assign outs = {cbe, psw, n64, wsw, tck, tms, tdo, sen};

  board_csr_bank #(.DEVICE_CODE(16'h1234), .VENDOR_CODE(16'h5678), .REVISION(6'h2a)) dut
  (.clk(clk), .resetn(resetn), .req(req), .req_write(req_write), .req_region0(req_region0),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata), .ack(ack), .rdata(rdata),
    .device_id(device_id), .vendor_id(vendor_id), .bar0_size(bar0_size),
    .bar1_size(bar1_size), .event_in(event_in), .irq(irq), .board_reset(board_reset),
    .ctrl_big_endian(cbe), .pio_swap(psw), .no_64bit(n64), .word_swap(wsw),
    .scan_tck(tck), .scan_tms(tms), .scan_tdo(tdo), .scan_tdi(scan_tdi), .scan_en(sen),
    .strap_low_volt(strap_low_volt), .strap_fast(strap_fast));

  pci_host_model host
  (.clk(clk), .req(req), .req_write(req_write), .req_region0(req_region0),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata), .ack(ack), .rdata(rdata));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // soft reset pulse width, counted on falling edges, away from the rising edge that launches it
  always @(negedge clk)
  begin
    if (board_reset === 1'b1)
      pulses++;
  end

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, 1'b1, a, 4'hf, d, rv);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, 1'b1, a, 4'hf, 32'h0, rv);
    chk("rdata", e, rv);
  endtask

  // one-cycle event pulse on source k
  task automatic fire(input int k);
    @(negedge clk);
    event_in = 8'h01 << k;
    @(negedge clk);
    event_in = 8'h00;
  endtask

  initial
  begin
    resetn = 1'b0;
    event_in = 8'h00;
    scan_tdi = 1'b1;
    strap_low_volt = 1'b1;
    strap_fast = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    chk("ids", 32'h1234_5678, {device_id, vendor_id});
    chk("bar0", 32'h0000_0100, bar0_size);
    chk("bar1", 32'h0010_0000, bar1_size);
    rdc(8'h04, 32'h0000_6a41);
    rdc(8'h00, 32'h0000_0000);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].rx);
      chk("outs", {24'h0, rows[i].ox}, {24'h0, outs});
    end
    // each source latches, raises irq, clears by writing one
    for (int k = 0; k < 8; k++)
    begin
      fire(k);
      rdc(8'h00, 32'h00ff_0000 | (32'h1 << k));
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h00, 32'h00ff_0000 | (32'h1 << k));
      rdc(8'h00, 32'h00ff_0000);
      chk("irq", 32'h0, {31'h0, irq});
    end
    wr(8'h00, 32'h0000_0000);
    fire(0);
    rdc(8'h00, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h0001_0000);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h00, 32'h0001_0001);
    rdc(8'h00, 32'h0001_0000);
    // partial width and foreign region accesses leave the bank alone
    host.xfer(1'b1, 1'b1, 8'h00, 4'h7, 32'h00ff_0000, rv);
    host.xfer(1'b1, 1'b0, 8'h00, 4'hf, 32'h0000_0000, rv);
    rdc(8'h00, 32'h0001_0000);
    host.xfer(1'b0, 1'b0, 8'h00, 4'hf, 32'h0, rv);
    chk("rdata", 32'h0, rv);
    // an event in the same cycle as its write-one-clear stays pending
    fork
      fire(0);
      wr(8'h00, 32'h0001_0001);
    join
    rdc(8'h00, 32'h0001_0001);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h04, 32'h0700_00be);
    chk("pulses", 32'h1, pulses);
    rdc(8'h00, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(8'h04, 32'h0000_6a41);
    chk("outs", 32'h0, {24'h0, outs});
    scan_tdi = 1'b0;
    strap_low_volt = 1'b0;
    strap_fast = 1'b1;
    repeat (3) @(negedge clk);
    rdc(8'h04, 32'h0000_aa01);
    tally_and_finish();
  end
endmodule
